// [rtl/srpd_device.sv]
// transceiver end: power-on reset, receiver reset and power-down of pins
// assumes the reference clock is the module clock and host keeps its side
// How it works
// RL1: reset runs whenever enabled with clock
// RL2: receive data and flags float during reset
// RL3: recovered word clock stays low in reset
// RL4: host keeps lock_n high with activity
// RL5: activity is serial transitions or loopback
// RL6: transmit-only host raises loopback with lock_n
// RL7: lock_n low after reset disables receive
// RL8: reset length fixed, below one millisecond
// RL9: host resets receiver right after power-up
// RL10: late lock_n held high one microsecond
// RL11: enable low floats transmit, data, low flag
// RL12: host keeps clock running in power-down
// RL13: transmitter works in every link configuration; here the serial output floats while internal loopback is on
// RL14: disabled high flag shows loss, active low
// RL15: receive outputs open after both resets
`timescale 1ns/1ps
`default_nettype none
module srpd_device #(
    parameter int unsigned POR_CYC = srpd_pkg::POR_DEV_CYC
) (
    input  wire logic        clock,
    input  wire logic        rstn,
    srpd_link_if.dev         link,
    input  wire logic [15:0] rxWordIn,
    input  wire logic [1:0]  rxKIn,
    input  wire logic        signalLossIn,
    input  wire logic        txSerialIn,
    output logic             porActive,
    output logic             rxReady,
    output logic             powerDown
);

    localparam int W = srpd_pkg::CNT_W;
    localparam logic [W-1:0] POR_LAST = W'(POR_CYC - 1);
    localparam logic [W-1:0] RX_HOLD = W'(srpd_pkg::RX_HOLD_CYC);

    typedef struct packed {
        logic         porDone;
        logic [W-1:0] porCnt;
        logic [W-1:0] rxCnt;
        logic         rxDone;
        logic         rxPrev;
        logic [15:0]  rxData;
        logic         rxDataOeN;
        logic         lowK;
        logic         lowKOeN;
        logic         highK;
        logic         highKOeN;
        logic         wordClk;
        logic         txOut;
        logic         txOeN;
        logic         porActive;
        logic         rxReady;
        logic         powerDown;
    } srpd_dev_st_t;

    // all pins with an output enable float out of reset; the word clock is held low
    localparam srpd_dev_st_t DEV_RST = '{
        rxDataOeN: srpd_pkg::PIN_RELEASE,
        lowKOeN:   srpd_pkg::PIN_RELEASE,
        highKOeN:  srpd_pkg::PIN_RELEASE,
        txOeN:     srpd_pkg::PIN_RELEASE,
        default:   '0
    };

    srpd_dev_st_t st_q;
    srpd_dev_st_t st_d;
    logic         act;
    logic         rxOpen;

    always_comb begin
        st_d = st_q;
        // a level change on the serial pair or loopback counts as activity
        act = link.internalLoopbackEnable
            | (link.serialReceivePair ^ st_q.rxPrev); // RL5
        st_d.rxPrev = link.serialReceivePair;
        st_d.txOut = txSerialIn;
        rxOpen = 1'b0;
        if (!link.enable) begin
            // power-down: everything restarts on the next enable
            st_d.powerDown = 1'b1;
            st_d.porDone = 1'b0;
            st_d.porCnt = '0;
            st_d.rxCnt = '0;
            st_d.rxDone = 1'b0;
            st_d.txOeN = srpd_pkg::PIN_RELEASE; // RL11
            st_d.rxDataOeN = srpd_pkg::PIN_RELEASE; // RL11
            st_d.lowKOeN = srpd_pkg::PIN_RELEASE; // RL11
            st_d.wordClk = 1'b0;
            // loss detect keeps running on the reference clock
            st_d.highK = ~signalLossIn; // RL14
            st_d.highKOeN = srpd_pkg::PIN_DRIVE; // RL14
        end else begin
            st_d.powerDown = 1'b0;
            // fixed count of reference cycles, so length scales with clock
            if (!st_q.porDone) begin
                st_d.porCnt = srpd_pkg::sat_inc(st_q.porCnt); // RL1
                st_d.porDone = (st_q.porCnt == POR_LAST); // RL8
            end
            // receiver reset: lock_n high with activity, in or after reset
            if (!link.lockToReferenceN) begin
                st_d.rxCnt = '0; // RL4
            end else if (act) begin
                st_d.rxCnt = srpd_pkg::sat_inc(st_q.rxCnt); // RL10
            end
            if (st_q.porDone && st_q.rxCnt >= RX_HOLD) begin
                st_d.rxDone = 1'b1; // RL15
            end
            // lock_n low after reset shuts the receive side
            rxOpen = st_q.rxDone & link.lockToReferenceN; // RL7
            // serial output floats only while looped back inside
            st_d.txOeN = link.internalLoopbackEnable
                ? srpd_pkg::PIN_RELEASE
                : srpd_pkg::PIN_DRIVE; // RL13
            if (rxOpen) begin
                st_d.rxData = signalLossIn
                    ? srpd_pkg::LOSS_WORD
                    : rxWordIn;
                st_d.lowK = signalLossIn | rxKIn[0];
                st_d.highK = signalLossIn | rxKIn[1];
                st_d.rxDataOeN = srpd_pkg::PIN_DRIVE; // RL15
                st_d.lowKOeN = srpd_pkg::PIN_DRIVE; // RL15
                st_d.highKOeN = srpd_pkg::PIN_DRIVE; // RL15
                st_d.wordClk = ~st_q.wordClk;
            end else begin
                st_d.rxDataOeN = srpd_pkg::PIN_RELEASE; // RL2
                st_d.lowKOeN = srpd_pkg::PIN_RELEASE; // RL2
                st_d.highKOeN = srpd_pkg::PIN_RELEASE; // RL2
                st_d.wordClk = 1'b0; // RL3
            end
        end
        st_d.porActive = link.enable & ~st_d.porDone;
        st_d.rxReady = rxOpen;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_q <= DEV_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign link.receiveDataBus = st_q.rxData;
    assign link.receiveDataBusOeN = st_q.rxDataOeN;
    assign link.lowByteKcodeFlag = st_q.lowK;
    assign link.lowByteKcodeFlagOeN = st_q.lowKOeN;
    assign link.highByteKcodeFlag = st_q.highK;
    assign link.highByteKcodeFlagOeN = st_q.highKOeN;
    assign link.recoveredWordClock = st_q.wordClk;
    assign link.serialTransmitPair = st_q.txOut;
    assign link.serialTransmitPairOeN = st_q.txOeN;
    assign porActive = st_q.porActive;
    assign rxReady = st_q.rxReady;
    assign powerDown = st_q.powerDown;

endmodule
`default_nettype wire

// [rtl/srpd_host.sv]
// host end: drives enable, lock_n, loopback and receive activity
// assumes the shared reference clock never stops, also in power-down
`timescale 1ns/1ps
`default_nettype none
module srpd_host #(
    parameter int unsigned POR_WAIT = srpd_pkg::POR_MAX_CYC
) (
    input  wire logic clock,
    input  wire logic rstn,
    srpd_link_if.host link,
    input  wire logic powerUpReq,
    input  wire logic txOnly,
    input  wire logic lateLock,
    output logic      linkReady,
    output logic      seqBusy
);

    localparam int W = srpd_pkg::CNT_W;
    localparam logic [W-1:0] WAIT_LAST = W'(POR_WAIT - 1);
    localparam logic [W-1:0] HOLD_LAST = W'(srpd_pkg::RX_HOLD_CYC - 1);

    typedef struct packed {
        srpd_pkg::srpd_host_state_t state;
        logic [W-1:0]               cnt;
        logic                       enable;
        logic                       lockN;
        logic                       loop;
        logic                       rxToggle;
        logic                       txOnlyLatched;
        logic                       ready;
        logic                       busy;
    } srpd_host_st_t;

    localparam srpd_host_st_t HOST_RST = '{
        state:   srpd_pkg::HS_OFF,
        lockN:   1'b1,
        default: '0
    };

    srpd_host_st_t st_q;
    srpd_host_st_t st_d;

    always_comb begin
        st_d = st_q;
        case (st_q.state)
            srpd_pkg::HS_OFF: begin
                st_d.enable = 1'b0;
                st_d.lockN = 1'b1;
                st_d.loop = 1'b0;
                // reset the receiver straight after power-up
                if (powerUpReq) begin // RL9
                    st_d.enable = 1'b1;
                    st_d.cnt = '0;
                    st_d.txOnlyLatched = txOnly;
                    st_d.lockN = ~lateLock; // RL4
                    st_d.loop = txOnly; // RL6
                    st_d.state = srpd_pkg::HS_POR;
                end
            end
            srpd_pkg::HS_POR: begin
                st_d.cnt = srpd_pkg::sat_inc(st_q.cnt);
                if (st_q.cnt == WAIT_LAST) begin
                    st_d.cnt = '0;
                    if (!st_q.lockN) begin
                        st_d.lockN = 1'b1; // RL10
                        st_d.state = srpd_pkg::HS_LATE;
                    end else begin
                        st_d.state = srpd_pkg::HS_RUN;
                    end
                end
            end
            srpd_pkg::HS_LATE: begin
                st_d.cnt = srpd_pkg::sat_inc(st_q.cnt);
                if (st_q.cnt == HOLD_LAST) begin // RL10
                    st_d.state = srpd_pkg::HS_RUN;
                end
            end
            default: begin
                // only now may transmit-only use pull lock_n low
                st_d.lockN = ~st_q.txOnlyLatched; // RL7
                st_d.loop = 1'b0;
            end
        endcase
        if (!powerUpReq && st_q.state != srpd_pkg::HS_OFF) begin
            st_d.enable = 1'b0;
            st_d.lockN = 1'b1;
            st_d.loop = 1'b0;
            st_d.state = srpd_pkg::HS_OFF;
        end
        // far-end transitions stand in for a live serial link
        st_d.rxToggle = (st_d.enable && !st_d.txOnlyLatched)
            ? ~st_q.rxToggle
            : st_q.rxToggle; // RL5
        st_d.ready = (st_d.state == srpd_pkg::HS_RUN);
        st_d.busy = (st_d.state == srpd_pkg::HS_POR)
            || (st_d.state == srpd_pkg::HS_LATE);
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_q <= HOST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign link.enable = st_q.enable;
    assign link.lockToReferenceN = st_q.lockN;
    assign link.internalLoopbackEnable = st_q.loop;
    assign link.serialReceivePair = st_q.rxToggle;
    assign linkReady = st_q.ready;
    assign seqBusy = st_q.busy;

endmodule
`default_nettype wire

// [rtl/srpd_link_if.sv]
// pins between the transceiver end and the host end
// assumes the testbench resolves pin levels from the active-low enables
`timescale 1ns/1ps
`default_nettype none
interface srpd_link_if;
    logic        enable;
    logic        lockToReferenceN;
    logic        internalLoopbackEnable;
    logic        serialReceivePair;
    logic [15:0] receiveDataBus;
    logic        receiveDataBusOeN;
    logic        lowByteKcodeFlag;
    logic        lowByteKcodeFlagOeN;
    logic        highByteKcodeFlag;
    logic        highByteKcodeFlagOeN;
    logic        recoveredWordClock;
    logic        serialTransmitPair;
    logic        serialTransmitPairOeN;

    modport dev (
        input  enable,
        input  lockToReferenceN,
        input  internalLoopbackEnable,
        input  serialReceivePair,
        output receiveDataBus,
        output receiveDataBusOeN,
        output lowByteKcodeFlag,
        output lowByteKcodeFlagOeN,
        output highByteKcodeFlag,
        output highByteKcodeFlagOeN,
        output recoveredWordClock,
        output serialTransmitPair,
        output serialTransmitPairOeN
    );

    modport host (
        output enable,
        output lockToReferenceN,
        output internalLoopbackEnable,
        output serialReceivePair,
        input  receiveDataBus,
        input  receiveDataBusOeN,
        input  lowByteKcodeFlag,
        input  lowByteKcodeFlagOeN,
        input  highByteKcodeFlag,
        input  highByteKcodeFlagOeN,
        input  recoveredWordClock,
        input  serialTransmitPair,
        input  serialTransmitPairOeN
    );
endinterface
`default_nettype wire

// [rtl/srpd_pkg.sv]
// shared constants, types and helpers of the reset and power-down sequencer
// assumes both ends run on one 25 MHz reference clock
`default_nettype none
package srpd_pkg;

    // reference clock
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;

    // power-on reset must end within this time; the longest time rounds down
    localparam int unsigned POR_MAX_NS = 1_000_000;
    localparam int unsigned POR_MAX_CYC = POR_MAX_NS * CLK_MHZ / 1000;

    // device power-on reset length in reference clock cycles
    localparam int unsigned POR_DEV_CYC = 20_000;

    // late lock release: least time high with activity, rounded up
    localparam int unsigned RX_HOLD_NS = 1000;
    localparam int unsigned RX_HOLD_CYC = (RX_HOLD_NS * CLK_MHZ + 999) / 1000;

    // counter width covering every count above
    localparam int unsigned CNT_W = 15;

    // output enables are active low
    localparam logic PIN_DRIVE = 1'b0;
    localparam logic PIN_RELEASE = 1'b1;

    // word shown on the receive bus while the signal is lost
    localparam logic [15:0] LOSS_WORD = 16'hffff;

    typedef enum logic [1:0] {
        HS_OFF,
        HS_POR,
        HS_LATE,
        HS_RUN
    } srpd_host_state_t;

    function automatic logic [CNT_W-1:0] sat_inc(
        input logic [CNT_W-1:0] v
    );
        logic [CNT_W-1:0] r;
        r = (v == {CNT_W{1'b1}}) ? v : v + 1'b1;
        return r;
    endfunction

endpackage
`default_nettype wire

// [sim/srpd_link_properties.sv]
// assertions on the pins between the host end and the transceiver end
// assumes one clock domain; the bench places it beside the link interface
`timescale 1ns/1ps
`default_nettype none
module srpd_link_properties #(
    parameter int unsigned POR_CYC = 40
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic enable,
    input wire logic lockToReferenceN,
    input wire logic internalLoopbackEnable,
    input wire logic serialReceivePair,
    input wire logic receiveDataBusOeN,
    input wire logic lowByteKcodeFlagOeN,
    input wire logic highByteKcodeFlagOeN,
    input wire logic recoveredWordClock,
    input wire logic serialTransmitPairOeN
);
    typedef struct packed {
        logic [15:0] enCnt;
        logic [15:0] lockRun;
        logic        rxPrev;
    } srpd_watch_t;
    srpd_watch_t watch_q;
    srpd_watch_t watch_d;

    // sampled cycles enabled, cycles enabled with lock_n high, last level
    always_comb begin
        watch_d = watch_q;
        watch_d.enCnt = enable ? watch_q.enCnt + 16'h0001 : 16'h0000;
        watch_d.lockRun = (enable && lockToReferenceN) ?
                          watch_q.lockRun + 16'h0001 : 16'h0000;
        watch_d.rxPrev = serialReceivePair;
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            watch_q <= '0;
        end else begin
            watch_q <= watch_d;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    por_float_a: assert property (
        enable && watch_q.enCnt >= 1 && watch_q.enCnt <= POR_CYC + 1
        |-> receiveDataBusOeN && lowByteKcodeFlagOeN && highByteKcodeFlagOeN)
        else $error("receive pins driven during power-on reset");
    wclk_low_a: assert property (
        enable && watch_q.enCnt >= 1 && watch_q.enCnt <= POR_CYC + 1
        |-> !recoveredWordClock)
        else $error("word clock not low during power-on reset");
    rx_open_a: assert property (
        watch_q.enCnt == POR_CYC + 2 && watch_q.lockRun == watch_q.enCnt
        |-> !receiveDataBusOeN)
        else $error("receive pins not open after reset");
    lock_close_a: assert property (
        !receiveDataBusOeN && !lockToReferenceN |=> receiveDataBusOeN)
        else $error("receive pins stay driven with lock_n low");
    pdown_float_a: assert property (
        !enable |=> receiveDataBusOeN && lowByteKcodeFlagOeN
        && serialTransmitPairOeN)
        else $error("pins driven in power-down");
    loss_flag_a: assert property (
        !enable |=> !highByteKcodeFlagOeN)
        else $error("high flag floats in power-down");
    rx_active_a: assert property (
        enable && lockToReferenceN && !internalLoopbackEnable
        && watch_q.enCnt >= 2 && watch_q.enCnt <= POR_CYC
        |-> serialReceivePair != watch_q.rxPrev)
        else $error("no receiver activity during reset");
    lock_late_a: assert property (
        $fell(lockToReferenceN) && $past(enable) |-> watch_q.enCnt > POR_CYC)
        else $error("lock_n lowered before reset end");
    lock_hold_a: assert property (
        $fell(lockToReferenceN) && $past(enable)
        |-> watch_q.lockRun >= srpd_pkg::RX_HOLD_CYC)
        else $error("lock_n high too briefly");
endmodule
`default_nettype wire

// [sim/test_serdes_reset_powerdown_ctrl.sv]
// bench joining host end and transceiver end, with a checker on the link
// assumes shortened reset counts so the run stays short
`timescale 1ns/1ps
`default_nettype none
module test_serdes_reset_powerdown_ctrl;
    localparam int POR_CYC = 40;
    localparam int POR_WAIT = 50;
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic        powerUpReq = 1'b0;
    logic        txOnly = 1'b0;
    logic        lateLock = 1'b0;
    logic [15:0] rxWordIn = 16'h0000;
    logic [1:0]  rxKIn = 2'h0;
    logic        signalLossIn = 1'b0;
    logic        txSerialIn = 1'b0;
    logic        porActive;
    logic        rxReady;
    logic        powerDown;
    logic        linkReady;
    logic        seqBusy;
    int          miscompares = 0;
    int          nCompared = 0;

    always #20 clock = ~clock;

    srpd_link_if link();
    srpd_device #(.POR_CYC(POR_CYC)) srpd_device_inst (
        .clock(clock), .rstn(rstn), .link(link), .rxWordIn(rxWordIn),
        .rxKIn(rxKIn), .signalLossIn(signalLossIn), .txSerialIn(txSerialIn),
        .porActive(porActive), .rxReady(rxReady), .powerDown(powerDown));
    srpd_host #(.POR_WAIT(POR_WAIT)) srpd_host_inst (
        .clock(clock), .rstn(rstn), .link(link), .powerUpReq(powerUpReq),
        .txOnly(txOnly), .lateLock(lateLock), .linkReady(linkReady),
        .seqBusy(seqBusy));
    srpd_link_properties #(.POR_CYC(POR_CYC)) srpd_link_properties_inst (
        .clock(clock), .rstn(rstn), .enable(link.enable),
        .lockToReferenceN(link.lockToReferenceN),
        .internalLoopbackEnable(link.internalLoopbackEnable),
        .serialReceivePair(link.serialReceivePair),
        .receiveDataBusOeN(link.receiveDataBusOeN),
        .lowByteKcodeFlagOeN(link.lowByteKcodeFlagOeN),
        .highByteKcodeFlagOeN(link.highByteKcodeFlagOeN),
        .recoveredWordClock(link.recoveredWordClock),
        .serialTransmitPairOeN(link.serialTransmitPairOeN));

    task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic end_sim;
        $display("compared %0d mismatches %0d", nCompared, miscompares);
        if (miscompares == 0 && nCompared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic power_up(input logic txo, input logic late);
        int cyc;
        int porCyc;
        powerUpReq = 1'b0;
        step(3);
        txOnly = txo;
        lateLock = late;
        powerUpReq = 1'b1;
        cyc = 0;
        porCyc = 0;
        while (linkReady !== 1'b1 && cyc < 400) begin
            step(1);
            cyc++;
            porCyc += (porActive === 1'b1);
            if (cyc == 5) begin
                cmp(porActive, 1'b1);
                cmp(seqBusy, 1'b1);
                cmp({link.receiveDataBusOeN,
                     link.recoveredWordClock}, 2'h2);
                cmp(link.internalLoopbackEnable, txo);
                cmp(link.lockToReferenceN, {~late});
            end
        end
        cmp(cyc, 1 + POR_WAIT + (late ? 25 : 0));
        cmp(porCyc >= POR_CYC - 1 && porCyc <= POR_CYC, 1'b1);
    endtask

    task automatic check_rx(input logic txo);
        logic [17:0] expQ[$];
        logic [17:0] e;
        for (int i = 0; i < 6; i++) begin
            rxWordIn = 16'($urandom);
            rxKIn = 2'($urandom);
            txSerialIn = 1'($urandom);
            signalLossIn = (i == 5);
            expQ.push_back(signalLossIn ? 18'h3ffff : {rxKIn, rxWordIn});
            step(2);
            e = expQ.pop_front();
            cmp({link.serialTransmitPairOeN, link.serialTransmitPair},
                {1'b0, txSerialIn});
            cmp(rxReady, {~txo});
            if (txo) begin
                cmp(link.receiveDataBusOeN, 1'b1);
            end else begin
                cmp({link.highByteKcodeFlag, link.lowByteKcodeFlag,
                     link.receiveDataBus}, e);
            end
        end
    endtask

    task automatic power_down;
        powerUpReq = 1'b0;
        for (int i = 0; i < 2; i++) begin
            signalLossIn = i[0];
            step(3);
            cmp({powerDown, link.recoveredWordClock}, 2'h2);
            cmp({link.receiveDataBusOeN, link.lowByteKcodeFlagOeN,
                 link.serialTransmitPairOeN, link.highByteKcodeFlagOeN},
                4'he);
            cmp(link.highByteKcodeFlag, {~signalLossIn});
        end
    endtask

    initial begin
        void'($urandom(61));
        step(6);
        rstn = 1'b1;
        for (int m = 0; m < 4; m++) begin
            power_up(m[0], m[1]);
            check_rx(m[0]);
            power_down();
        end
        // reset in mid-run, then a full restart
        power_up(1'b0, 1'b0);
        rstn = 1'b0;
        step(2);
        cmp({link.enable, link.receiveDataBusOeN}, 2'h1);
        rstn = 1'b1;
        power_up(1'b0, 1'b0);
        check_rx(1'b0);
        end_sim();
    end

    initial begin
        #(40 * 10000);
        miscompares++;
        end_sim();
    end
endmodule
`default_nettype wire
